// File: core/asfp_pkg.sv
/*
  Constants for the asynchronous serial unit six: register map, field
  positions, reset values, parity codes and oversampling counts.
  Assumes an APB master with byte addresses and a 25 MHz clock.
*/
// How it works
// - Pins serial only with power and enable
// - Every frame opens with one start bit
// - Seven or eight character bits per frame
// - Parity even, odd, zero or none
// - Transmitter sends one or two stop bits
// - Length, parity, stops from frame mode register
// - Control bit 1 picks LSB or MSB first
// - Control bit 0 inverts the transmit pin
// - Parity codes: none, zero, odd, even
// - Receiver checks exactly one stop bit
// - Zero parity is never checked on receive
package asfp_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_TXDATA = 8'h0C;
  localparam logic [7:0] ADDR_RXDATA = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQEN = 8'h18;
  localparam logic [7:0] ADDR_IRQCLR = 8'h1C;
  localparam logic [7:0] ADDR_PORT = 8'h20;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int MODE_POWER = 7;
  localparam int MODE_TXEN = 6;
  localparam int MODE_RXEN = 5;
  localparam int MODE_PAR_HI = 4;
  localparam int MODE_PAR_LO = 3;
  localparam int MODE_CLEN = 2;
  localparam int MODE_STOP = 1;
  localparam logic [7:0] MODE_RESET = 8'h04;
  localparam int CTRL_INVERT = 0;
  localparam int CTRL_LSB = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  localparam logic [15:0] BAUD_RESET = 16'h000D;
  localparam int ST_TXDONE = 0;
  localparam int ST_RXDONE = 1;
  localparam int ST_PERR = 2;
  localparam int ST_FERR = 3;
  localparam int ST_OVR = 4;
  localparam int ST_TXBUSY = 8;
  localparam int ST_RXBUSY = 9;
  localparam int PORT_TXLATCH = 0;
  localparam int PORT_TXDIR = 1;
  localparam int PORT_RXLATCH = 2;
  localparam int PORT_RXDIR = 3;
  localparam int PORT_TXPIN = 4;
  localparam int PORT_RXPIN = 5;
  localparam logic [3:0] PORT_RESET = 4'hA;
  // ----------------------------------------------------------------
  // Parity codes and bit timing
  // ----------------------------------------------------------------
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_MID = 4'h7;
  typedef enum logic [2:0] {FR_IDLE, FR_START, FR_DATA, FR_PAR, FR_STOP} asfp_frame_type;
endpackage : asfp_pkg

// File: core/asfp_uart.sv
/*
  Asynchronous serial unit six with APB register slave, pin multiplexing,
  framed transmitter and receiver, and sticky-status interrupt.
  Assumes one 25 MHz clock, synchronous reset and an APB master.
*/
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps
module asfp_uart (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic serialOutPinIn,
  output logic serialOutPinOut,
  output logic serialOutPinOeN,
  input wire logic serialInPinIn,
  output logic serialInPinOut,
  output logic serialInPinOeN
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] mode, next_mode;
  logic [1:0] ctrl, next_ctrl;
  logic [15:0] baud, next_baud;
  logic [4:0] status, next_status;
  logic [4:0] irqEn, next_irqEn;
  logic [3:0] port, next_port;
  logic [7:0] rxData, next_rxData;
  logic rxFull, next_rxFull;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq;
  logic next_outPin, next_outOeN, next_inPin, next_inOeN;
  logic [15:0] divCnt, next_divCnt;
  logic outSync1, outSync2, inSync1, inSync2;
  asfp_pkg::asfp_frame_type txState, next_txState, rxState, next_rxState;
  logic [7:0] txShift, next_txShift, rxShift, next_rxShift;
  logic [2:0] txBitCnt, next_txBitCnt, rxBitCnt, next_rxBitCnt;
  logic [3:0] txTick, next_txTick, rxTick, next_rxTick;
  logic txParBit, next_txParBit, txStop2, next_txStop2, rxParOk, next_rxParOk;
  logic txLine, txRun, rxRun, tick, txLoad, mapped, wrEn;
  logic evTx, evRx, evPerr, evFerr, evOvr;
  logic [2:0] lastBit;
  logic [1:0] parMode;
  logic [4:0] clrBits;

  // Bit order: slot 0 is the first bit on the wire
  function automatic logic [7:0] orderBits(input logic [7:0] d, input logic clen,
                                           input logic lsb);
    logic [7:0] o;
    o = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (lsb && (clen || i < 7)) begin
        o[i] = d[i];
      end else if (clen) begin
        o[i] = d[7 - i];
      end else if (i < 7) begin
        o[i] = d[6 - i];
      end
    end
    return o;
  endfunction : orderBits

  // Mode fields shared by both directions
  assign txRun = mode[asfp_pkg::MODE_POWER] & mode[asfp_pkg::MODE_TXEN];
  assign rxRun = mode[asfp_pkg::MODE_POWER] & mode[asfp_pkg::MODE_RXEN];
  assign parMode = {mode[asfp_pkg::MODE_PAR_HI], mode[asfp_pkg::MODE_PAR_LO]};
  assign lastBit = mode[asfp_pkg::MODE_CLEN] ? 3'h7 : 3'h6;
  assign wrEn = psel & penable & pready & pwrite;
  assign txLoad = wrEn & (paddr == asfp_pkg::ADDR_TXDATA) & txRun &
                  (txState == asfp_pkg::FR_IDLE);
  assign clrBits = (wrEn && paddr == asfp_pkg::ADDR_IRQCLR) ? pwdata[4:0] : 5'h00;

  // ----------------------------------------------------------------
  // Pin synchronisers and baud divider
  // ----------------------------------------------------------------
  // Two flip-flops on each pin input
  always_ff @(posedge clk) begin
    outSync1 <= serialOutPinIn;
    outSync2 <= outSync1;
    inSync1 <= serialInPinIn;
    inSync2 <= inSync1;
  end

  // Sixteen ticks per bit time, halted while unpowered
  always_comb begin
    tick = 1'b0;
    next_divCnt = divCnt - 16'h0001;
    if (!mode[asfp_pkg::MODE_POWER]) begin
      next_divCnt = 16'h0000;
    end else if (divCnt == 16'h0000) begin
      tick = 1'b1;
      next_divCnt = baud;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      divCnt <= 16'h0000;
    end else begin
      divCnt <= next_divCnt;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  // Frame sequencer; each bit lasts sixteen ticks
  always_comb begin
    next_txState = txState;
    next_txShift = txShift;
    next_txBitCnt = txBitCnt;
    next_txTick = txTick;
    next_txParBit = txParBit;
    next_txStop2 = txStop2;
    evTx = 1'b0;
    if (tick && txState != asfp_pkg::FR_IDLE) begin
      next_txTick = txTick + 4'h1;
    end
    if (!txRun) begin
      next_txState = asfp_pkg::FR_IDLE;
    end else if (txLoad) begin
      next_txState = asfp_pkg::FR_START;
      next_txTick = 4'h0;
      next_txBitCnt = 3'h0;
      next_txStop2 = mode[asfp_pkg::MODE_STOP];
      next_txShift = orderBits(pwdata[7:0], mode[asfp_pkg::MODE_CLEN],
                               ctrl[asfp_pkg::CTRL_LSB]);
      // Parity over the character bits only
      unique case (parMode)
        asfp_pkg::PAR_ODD: next_txParBit = ~(^orderBits(pwdata[7:0],
                           mode[asfp_pkg::MODE_CLEN], 1'b1));
        asfp_pkg::PAR_EVEN: next_txParBit = ^orderBits(pwdata[7:0],
                            mode[asfp_pkg::MODE_CLEN], 1'b1);
        default: next_txParBit = 1'b0;
      endcase
    end else if (tick && txTick == asfp_pkg::TICK_LAST) begin
      unique case (txState)
        asfp_pkg::FR_IDLE: next_txState = asfp_pkg::FR_IDLE;
        asfp_pkg::FR_START: next_txState = asfp_pkg::FR_DATA;
        asfp_pkg::FR_DATA: begin
          next_txShift = {1'b0, txShift[7:1]};
          next_txBitCnt = txBitCnt + 3'h1;
          if (txBitCnt == lastBit) begin
            next_txState = (parMode == asfp_pkg::PAR_NONE) ?
                           asfp_pkg::FR_STOP : asfp_pkg::FR_PAR;
          end
        end
        asfp_pkg::FR_PAR: next_txState = asfp_pkg::FR_STOP;
        asfp_pkg::FR_STOP: begin
          if (txStop2) begin
            next_txStop2 = 1'b0;
          end else begin
            next_txState = asfp_pkg::FR_IDLE;
            evTx = 1'b1;
          end
        end
      endcase
    end
  end

  // Line level before inversion
  always_comb begin
    unique case (txState)
      asfp_pkg::FR_START: txLine = 1'b0;
      asfp_pkg::FR_DATA: txLine = txShift[0];
      asfp_pkg::FR_PAR: txLine = txParBit;
      default: txLine = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      txState <= asfp_pkg::FR_IDLE;
      txShift <= 8'h00;
      txBitCnt <= 3'h0;
      txTick <= 4'h0;
      txParBit <= 1'b0;
      txStop2 <= 1'b0;
    end else begin
      txState <= next_txState;
      txShift <= next_txShift;
      txBitCnt <= next_txBitCnt;
      txTick <= next_txTick;
      txParBit <= next_txParBit;
      txStop2 <= next_txStop2;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  // Start checked at mid bit, later bits sampled every sixteen ticks
  always_comb begin
    next_rxState = rxState;
    next_rxShift = rxShift;
    next_rxBitCnt = rxBitCnt;
    next_rxTick = rxTick;
    next_rxParOk = rxParOk;
    next_rxData = rxData;
    next_rxFull = rxFull;
    evRx = 1'b0;
    evPerr = 1'b0;
    evFerr = 1'b0;
    evOvr = 1'b0;
    if (psel && !penable && !pwrite && paddr == asfp_pkg::ADDR_RXDATA) begin
      next_rxFull = 1'b0;
    end
    if (tick) begin
      next_rxTick = rxTick + 4'h1;
    end
    if (!rxRun) begin
      next_rxState = asfp_pkg::FR_IDLE;
    end else begin
      unique case (rxState)
        asfp_pkg::FR_IDLE: begin
          next_rxTick = 4'h0;
          next_rxBitCnt = 3'h0;
          next_rxShift = 8'h00;
          if (!inSync2) begin
            next_rxState = asfp_pkg::FR_START;
          end
        end
        asfp_pkg::FR_START: begin
          if (tick && rxTick == asfp_pkg::TICK_MID) begin
            next_rxTick = 4'h0;
            next_rxState = inSync2 ? asfp_pkg::FR_IDLE : asfp_pkg::FR_DATA;
          end
        end
        asfp_pkg::FR_DATA: begin
          if (tick && rxTick == asfp_pkg::TICK_LAST) begin
            if (ctrl[asfp_pkg::CTRL_LSB]) begin
              next_rxShift[rxBitCnt] = inSync2;
            end else begin
              next_rxShift[lastBit - rxBitCnt] = inSync2;
            end
            next_rxBitCnt = rxBitCnt + 3'h1;
            if (rxBitCnt == lastBit) begin
              next_rxState = (parMode == asfp_pkg::PAR_NONE) ?
                             asfp_pkg::FR_STOP : asfp_pkg::FR_PAR;
            end
          end
        end
        asfp_pkg::FR_PAR: begin
          if (tick && rxTick == asfp_pkg::TICK_LAST) begin
            next_rxState = asfp_pkg::FR_STOP;
            unique case (parMode)
              asfp_pkg::PAR_ODD: next_rxParOk = (^rxShift) ^ inSync2;
              asfp_pkg::PAR_EVEN: next_rxParOk = ~((^rxShift) ^ inSync2);
              default: next_rxParOk = 1'b1;
            endcase
          end
        end
        asfp_pkg::FR_STOP: begin
          // Only one stop bit is looked at
          if (tick && rxTick == asfp_pkg::TICK_LAST) begin
            next_rxState = asfp_pkg::FR_IDLE;
            next_rxData = rxShift;
            next_rxFull = 1'b1;
            evRx = 1'b1;
            evOvr = rxFull;
            evFerr = ~inSync2;
            evPerr = (parMode == asfp_pkg::PAR_ODD || parMode == asfp_pkg::PAR_EVEN)
                     && !rxParOk;
          end
        end
        default: next_rxState = asfp_pkg::FR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rxState <= asfp_pkg::FR_IDLE;
      rxShift <= 8'h00;
      rxBitCnt <= 3'h0;
      rxTick <= 4'h0;
      rxParOk <= 1'b1;
      rxData <= 8'h00;
      rxFull <= 1'b0;
    end else begin
      rxState <= next_rxState;
      rxShift <= next_rxShift;
      rxBitCnt <= next_rxBitCnt;
      rxTick <= next_rxTick;
      rxParOk <= next_rxParOk;
      rxData <= next_rxData;
      rxFull <= next_rxFull;
    end
  end

  // ----------------------------------------------------------------
  // Registers, APB answer, interrupt and pins
  // ----------------------------------------------------------------
  // Writes land in the access cycle; reads are prepared in setup
  always_comb begin
    next_mode = mode;
    next_ctrl = ctrl;
    next_baud = baud;
    next_irqEn = irqEn;
    next_port = port;
    mapped = (paddr <= asfp_pkg::ADDR_PORT) && (paddr[1:0] == 2'h0);
    if (wrEn) begin
      unique case (paddr)
        asfp_pkg::ADDR_MODE: next_mode = pwdata[7:0];
        asfp_pkg::ADDR_CTRL: next_ctrl = pwdata[1:0];
        asfp_pkg::ADDR_BAUD: next_baud = pwdata[15:0];
        asfp_pkg::ADDR_IRQEN: next_irqEn = pwdata[4:0];
        asfp_pkg::ADDR_PORT: next_port = pwdata[3:0];
        default: next_port = port;
      endcase
    end
    // Sticky events; a set wins over a clear in the same cycle
    next_status = (status & ~clrBits) | {evOvr, evFerr, evPerr, evRx, evTx};
    next_irq = |(next_status & irqEn);
    next_pready = psel & ~penable;
    next_pslverr = psel & ~penable & ~mapped;
    next_prdata = 32'h00000000;
    if (psel && !penable) begin
      unique case (paddr)
        asfp_pkg::ADDR_MODE: next_prdata[7:0] = mode;
        asfp_pkg::ADDR_CTRL: next_prdata[1:0] = ctrl;
        asfp_pkg::ADDR_BAUD: next_prdata[15:0] = baud;
        asfp_pkg::ADDR_RXDATA: next_prdata[7:0] = rxData;
        asfp_pkg::ADDR_STATUS: begin
          next_prdata[4:0] = status;
          next_prdata[asfp_pkg::ST_TXBUSY] = (txState != asfp_pkg::FR_IDLE);
          next_prdata[asfp_pkg::ST_RXBUSY] = (rxState != asfp_pkg::FR_IDLE);
        end
        asfp_pkg::ADDR_IRQEN: next_prdata[4:0] = irqEn;
        asfp_pkg::ADDR_PORT: begin
          next_prdata[3:0] = port;
          next_prdata[asfp_pkg::PORT_TXPIN] = outSync2;
          next_prdata[asfp_pkg::PORT_RXPIN] = inSync2;
        end
        default: next_prdata = 32'h00000000;
      endcase
    end
    // Transmit pin: serial output, else general port
    if (txRun) begin
      next_outPin = txLine ^ ctrl[asfp_pkg::CTRL_INVERT];
      next_outOeN = 1'b0;
    end else begin
      next_outPin = port[asfp_pkg::PORT_TXLATCH];
      next_outOeN = port[asfp_pkg::PORT_TXDIR];
    end
    // Receive pin: input only while receiving, else general port
    next_inPin = port[asfp_pkg::PORT_RXLATCH];
    next_inOeN = rxRun ? 1'b1 : port[asfp_pkg::PORT_RXDIR];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode <= asfp_pkg::MODE_RESET;
      ctrl <= asfp_pkg::CTRL_RESET;
      baud <= asfp_pkg::BAUD_RESET;
      status <= 5'h00;
      irqEn <= 5'h00;
      port <= asfp_pkg::PORT_RESET;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      serialOutPinOut <= 1'b1;
      serialOutPinOeN <= 1'b1;
      serialInPinOut <= 1'b0;
      serialInPinOeN <= 1'b1;
    end else begin
      mode <= next_mode;
      ctrl <= next_ctrl;
      baud <= next_baud;
      status <= next_status;
      irqEn <= next_irqEn;
      port <= next_port;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
      serialOutPinOut <= next_outPin;
      serialOutPinOeN <= next_outOeN;
      serialInPinOut <= next_inPin;
      serialInPinOeN <= next_inOeN;
    end
  end
endmodule : asfp_uart

// File: testbench/asfp_uart_props.sv
/* Port checker for asfp_uart: bus answers, readback, pin routing.
   Assumes it is bound into every asfp_uart instance. */
`timescale 1ns/10ps
module asfp_uart_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic serialOutPinIn,
  input wire logic serialOutPinOut,
  input wire logic serialOutPinOeN,
  input wire logic serialInPinIn,
  input wire logic serialInPinOut,
  input wire logic serialInPinOeN
);
  // ------------------------------
  // Shadow registers
  // ------------------------------
  logic [7:0] modeReg, modeQ, next_mode;
  logic [3:0] portReg, portQ, next_port;
  logic [1:0] ctrlReg, next_ctrl;
  logic [4:0] ienReg, next_ien;
  logic armed, wrAcc, bad, txOn, rxOn;
  // Write strobe, bad address, serial routing of the pins
  assign wrAcc = psel && penable && pready && pwrite;
  assign bad = (paddr > 8'h20) || (paddr[1:0] != 2'h0);
  assign txOn = modeQ[7] && modeQ[6];
  assign rxOn = modeQ[7] && modeQ[5];
  // Next shadow values from bus writes
  always_comb begin
    next_mode = (wrAcc && paddr == 8'h00) ? pwdata[7:0] : modeReg;
    next_ctrl = (wrAcc && paddr == 8'h04) ? pwdata[1:0] : ctrlReg;
    next_ien = (wrAcc && paddr == 8'h18) ? pwdata[4:0] : ienReg;
    next_port = (wrAcc && paddr == 8'h20) ? pwdata[3:0] : portReg;
  end
  // Pins lag the registers by one cycle, so keep late copies
  always_ff @(posedge clk) begin
    modeReg <= reset ? asfp_pkg::MODE_RESET : next_mode;
    ctrlReg <= reset ? asfp_pkg::CTRL_RESET : next_ctrl;
    ienReg <= reset ? 5'h00 : next_ien;
    portReg <= reset ? asfp_pkg::PORT_RESET : next_port;
    modeQ <= modeReg;
    portQ <= portReg;
    armed <= !reset;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_setup_answered: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_bad_address: assert property (pready |-> pslverr == bad && (pwrite || !bad || prdata == 0))
    else $error("wrong answer to address");
  a_mode_readback: assert property (
    pready && !pwrite && paddr == 8'h00 |-> prdata == {24'h0, modeReg})
    else $error("mode readback wrong");
  a_ctrl_readback: assert property (
    pready && !pwrite && paddr == 8'h04 |-> prdata == {30'h0, ctrlReg})
    else $error("control readback wrong");
  a_tx_pin_route: assert property (armed |-> serialOutPinOeN == (txOn ? 1'b0 : portQ[1])
    && (txOn || serialOutPinOut == portQ[0]))
    else $error("transmit pin routing wrong");
  a_rx_pin_route: assert property (
    armed |-> serialInPinOeN == (rxOn ? 1'b1 : portQ[3]) && serialInPinOut == portQ[2])
    else $error("receive pin routing wrong");
  a_irq_masked: assert property (armed && $past(ienReg) == 5'h00 |-> !irq)
    else $error("irq while all masked");
  a_start_bit: assert property (wrAcc && paddr == 8'h0C && modeReg[7] && modeReg[6]
    && serialOutPinOut != ctrlReg[0] |-> ##3 serialOutPinOut == ctrlReg[0][*8])
    else $error("start bit missing");
endmodule : asfp_uart_props

bind asfp_uart asfp_uart_props asfp_uart_props_i (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .serialOutPinIn(serialOutPinIn),
  .serialOutPinOut(serialOutPinOut), .serialOutPinOeN(serialOutPinOeN),
  .serialInPinIn(serialInPinIn), .serialInPinOut(serialInPinOut),
  .serialInPinOeN(serialInPinOeN));

// File: testbench/asfp_remote_node.sv
/* Remote serial node: sends frames on the receive line and samples
   frames from the transmit line. Assumes 16 clocks per bit. */
`timescale 1ns/10ps
module asfp_remote_node (
  input wire logic clk,
  input wire logic txLine,
  output logic rxLine
);
  // Line idles high between frames
  initial rxLine = 1'b1;
  // Drive frame bits first to last, one bit time each
  task automatic send(input logic [11:0] b, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      rxLine <= b[i];
      repeat (16) @(posedge clk);
    end
    rxLine <= 1'b1;
  endtask : send
  // Wait for the start level, then sample each bit in its middle
  task automatic grab(input logic inv, input int n, output logic [11:0] b, output logic ok);
    int i;
    b = 12'h000;
    for (i = 0; i < 4000 && txLine !== inv; i++) @(posedge clk);
    ok = i < 4000;
    repeat (8) @(posedge clk);
    for (i = 0; i < n; i++) begin
      b[i] = txLine;
      repeat (16) @(posedge clk);
    end
  endtask : grab
endmodule : asfp_remote_node

// File: testbench/tb_asfp_uart.sv
/* Bench for asfp_uart: registers, pins, framing against a bench model.
   Assumes the remote node model and the checker are compiled first. */
`timescale 1ns/10ps
module tb_asfp_uart;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, txOut, txOeN, rxOut, rxOeN, nodeLine, ok;
  wire logic txWire = txOeN ? 1'b1 : txOut;
  wire logic rxWire = rxOeN ? nodeLine : rxOut;
  int nMismatch = 0;
  int checked = 0;
  int k, i;
  logic fb[$];
  logic [11:0] got, sb;
  logic [7:0] md, d;
  logic [1:0] ct;
  always #20 clk = ~clk;
  asfp_uart asfp_uart_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .serialOutPinIn(txWire), .serialOutPinOut(txOut),
    .serialOutPinOeN(txOeN), .serialInPinIn(rxWire), .serialInPinOut(rxOut),
    .serialInPinOeN(rxOeN));
  asfp_remote_node asfp_remote_node_i (.clk(clk), .txLine(txWire), .rxLine(nodeLine));
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic endSim();
    if (nMismatch == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : endSim
  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      nMismatch++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : cmp
  // One APB transfer; read data masked and compared, error answer checked
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
    input logic [31:0] m, input logic [31:0] e);
    int j;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (j = 0; j < 20 && pready !== 1'b1; j++) @(posedge clk);
    if (j == 20) begin
      cmp(0, 1, "no pready");
      endSim();
    end
    if (!w) cmp(prdata & m, e, "read data");
    cmp(pslverr, (a > 8'h20) || (a[1:0] != 2'h0), "slave error");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, 32'h0, 32'h0);
  endtask : wr
  // Bench model of one frame, before any inversion
  task automatic frame();
    int n, j;
    logic p;
    n = md[2] ? 8 : 7;
    p = ^(d & (md[2] ? 8'hFF : 8'h7F));
    fb = {1'b0};
    for (j = 0; j < n; j++) fb.push_back(d[ct[1] ? j : n - 1 - j]);
    if (md[4:3] != 2'h0) fb.push_back(md[4] & (p ^ !md[3]));
    fb.push_back(1'b1);
    if (md[1]) fb.push_back(1'b1);
  endtask : frame
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    void'($urandom(96));
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, 8'h00, 0, 32'hFF, asfp_pkg::MODE_RESET);
    apb(1'b0, 8'h04, 0, 32'h3, asfp_pkg::CTRL_RESET);
    apb(1'b0, 8'h08, 0, 32'hFFFF, asfp_pkg::BAUD_RESET);
    apb(1'b0, 8'h20, 0, 32'hF, asfp_pkg::PORT_RESET);
    apb(1'b0, 8'h24, 0, 32'hFFFFFFFF, 32'h0);
    apb(1'b0, 8'h06, 0, 32'hFFFFFFFF, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h20, 32'h5);
    repeat (4) @(posedge clk);
    cmp({txOeN, txOut, rxOeN, rxOut}, 4'h5, "port pins");
    apb(1'b0, 8'h20, 0, 32'h3F, 32'h35);
    wr(8'h18, 32'h1);
    // Transmit every parity code and both lengths
    for (k = 0; k < 8; k++) begin
      ct = 2'($urandom);
      d = 8'($urandom);
      md = {3'b110, k[1:0], k[2], 1'($urandom), 1'b0};
      frame();
      wr(8'h04, ct);
      wr(8'h00, 32'h80);
      wr(8'h00, md);
      wr(8'h0C, d);
      asfp_remote_node_i.grab(ct[0], fb.size(), got, ok);
      cmp(ok, 1, "no start bit");
      if (!ok) endSim();
      for (i = 0; i < fb.size(); i++) cmp(got[i], fb[i] ^ ct[0], "tx bit");
      apb(1'b0, 8'h14, 0, 32'h1, 32'h1);
      cmp(irq, 1, "irq not raised");
      wr(8'h1C, 32'h1F);
      repeat (2) @(posedge clk);
      cmp(irq, 0, "irq not cleared");
    end
    wr(8'h18, 32'h0);
    // Receive with two stops set, one sent; 8-bit frames with a parity bit get it flipped
    for (k = 0; k < 8; k++) begin
      ct = 2'($urandom);
      d = 8'($urandom);
      md = {3'b101, k[1:0], k[2], 1'b1, 1'b0};
      frame();
      if (k[2] && md[4:3] != 2'h0) fb[fb.size() - 3] = !fb[fb.size() - 3];
      if (k == 4) fb[fb.size() - 2] = 1'b0;
      for (i = 0; i < fb.size(); i++) sb[i] = fb[i];
      wr(8'h04, ct);
      wr(8'h00, 32'h80);
      wr(8'h00, md);
      asfp_remote_node_i.send(sb, fb.size() - 1);
      repeat (4) @(posedge clk);
      apb(1'b0, 8'h10, 0, md[2] ? 32'hFF : 32'h7F, d & (md[2] ? 8'hFF : 8'h7F));
      apb(1'b0, 8'h14, 0, 32'h1E, {k == 4, k[2] && md[4], 2'h2});
      cmp(irq, 0, "irq while masked");
      wr(8'h1C, 32'h1F);
    end
    // Two frames with no read between raise overrun and keep the parity error
    asfp_remote_node_i.send(sb, fb.size() - 1);
    repeat (4) @(posedge clk);
    asfp_remote_node_i.send(sb, fb.size() - 1);
    repeat (4) @(posedge clk);
    apb(1'b0, 8'h14, 0, 32'h1E, 32'h16);
    endSim();
  end
endmodule : tb_asfp_uart
